// File: bench/ciop_chk.sv
// Port-level assertions for the clocked I/O port unit.
`timescale 1ns/1ps
module ciop_chk
    import ciop_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [NPIN-1:0] pin_oe_o,
    input wire logic [NPORT-1:0] strobe_out_o,
    input wire logic [NPORT-1:0] event_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    logic acc;
    logic link_q;
    logic link_d;
    assign acc = psel_i && penable_i;
    // The link state is shadowed here because the checker cannot see the register itself.
    always_comb begin
        link_d = link_q;
        if (acc && pwrite_i && paddr_i == LINK_CTRL) begin
            link_d = pwdata_i[0];
        end
    end
    always_ff @(posedge sys_clk_i) begin
        link_q <= reset_i ? 1'b0 : link_d;
    end
    a_pready_access: assert property (acc |-> pready_o)
        else $error("pready missing in access phase");
    a_pready_single: assert property (pready_o |=> !pready_o)
        else $error("pready held longer than one cycle");
    a_err_with_ready: assert property (pslverr_o |-> pready_o && acc)
        else $error("pslverr outside an access phase");
    a_err_unmapped: assert property (acc && (paddr_i[1:0] != 2'b00 || paddr_i > LINK_CTRL)
        |-> pslverr_o)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (acc && paddr_i[1:0] == 2'b00 && paddr_i < 8'h30
        |-> !pslverr_o)
        else $error("port register access refused");
    a_err_rdata_zero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
        else $error("refused read returned data");
    a_rdata_hold: assert property (!$past(psel_i && !penable_i) |-> $stable(prdata_o))
        else $error("read data changed without a setup");
    a_link_release: assert property (link_q && $past(link_q, 3)
        |-> pin_oe_o[7:6] == 2'b00)
        else $error("pins shared with the link still driven");
    a_quiet_reset: assert property ($past(reset_i)
        |-> pin_oe_o == '0 && event_o == '0 && strobe_out_o == '0)
        else $error("outputs active right after reset");
    cover property (acc && pwrite_i && paddr_i == LINK_CTRL);
    cover property (pslverr_o);
    cover property (|event_o);
    cover property (|strobe_out_o);
endmodule
bind ciop_top ciop_chk chk_u (.sys_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pin_oe_o, .strobe_out_o, .event_o);

// File: bench/ciop_pins_model.sv
// External hardware on the pins: pull-downs, a driven pattern and a gated clock.
`timescale 1ns/1ps
module ciop_pins_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_o,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    input wire logic clk_run_i,
    output logic [7:0] pin_i,
    output logic [2:0] strobe_in_o
);
    logic ext_clk_q = 1'b0;
    logic [1:0] half_q = 2'b00;
    // The clock stands still between bursts so every rising edge is counted by the bench.
    always_ff @(posedge sys_clk_i) begin
        half_q <= half_q + 2'd1;
        if (clk_run_i && half_q[0]) begin
            ext_clk_q <= !ext_clk_q;
        end
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_i[i] = pin_oe_o[i] ? pin_o[i] : (ext_en_i[i] ? ext_val_i[i] : 1'b0);
        end
        if (clk_run_i) begin
            pin_i[0] = ext_clk_q;
        end
    end
    assign strobe_in_o = 3'b111;
endmodule

// File: bench/ciop_top_test.sv
// Self-checking bench for the clocked I/O port unit.
`timescale 1ns/1ps
module ciop_top_test import ciop_pkg::*;;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o, rd, t0, w;
    int stb_seen = 0;
    int s0;
    logic pready_o, pslverr_o, er, clk_run = 1'b0;
    logic [7:0] pin_i, pin_o, pin_oe_o, r, ext_en = 8'h00, ext_val = 8'h00;
    logic [2:0] strobe_in_i, strobe_out_o, event_o;
    int bad_count = 0;
    int comparisons = 0;
    int seed = 51357;
    always #25 sys_clk_i = !sys_clk_i;
    always @(posedge sys_clk_i) begin
        if (strobe_out_o[2] === 1'b1) stb_seen++;
    end
    ciop_top dut_u (.sys_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pin_i, .pin_o, .pin_oe_o,
        .strobe_in_i, .strobe_out_o, .event_o);
    ciop_pins_model pins_u (.sys_clk_i, .pin_o, .pin_oe_o, .ext_en_i(ext_en),
        .ext_val_i(ext_val), .clk_run_i(clk_run), .pin_i, .strobe_in_o(strobe_in_i));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) bad_count++;
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wait_ev(input int i);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (event_o[i] !== 1'b1 && n < 200);
        chk("event", 32'h1, {31'h0, event_o[i]});
    endtask
    task automatic tdiff(input logic [7:0] a, input int gap, input logic [31:0] e);
        logic [31:0] s;
        apb(1'b0, a, 32'h0);
        s = rd;
        repeat (gap) @(posedge sys_clk_i);
        apb(1'b0, a, 32'h0);
        chk("count", e, (rd - s) & 32'hFFFF);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #(50 * 4000);
        bad_count++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        for (int p = 0; p < 3; p++) begin
            apb(1'b0, 8'(16 * p), 32'h0);
            chk("ctrl", 32'h0, rd);
        end
        apb(1'b1, CB_BASE, 32'h1);
        apb(1'b0, CB_BASE, 32'h0);
        chk("cb0", 32'h0, rd);
        apb(1'b0, 8'h70, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        for (int k = 0; k < 4; k++) begin
            r = 8'($random(seed));
            apb(1'b1, 8'h10, k[0] ? 32'h7 : 32'h3);
            apb(1'b1, 8'h14, {28'h0, r[3:0]});
            wait_ev(1);
            repeat (2) @(posedge sys_clk_i);
            chk("oe", k[0] ? {28'h0, ~r[3:0]} : 32'hF, {28'h0, pin_oe_o[3:0]});
            chk("level", k[0] ? 32'h0 : {28'h0, r[3:0]}, {28'h0, pin_i[3:0]});
        end
        apb(1'b1, 8'h10, 32'h3);
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h14, {28'h0, r[3:0]});
        apb(1'b1, 8'h04, {31'h0, ~r[0]});
        wait_ev(0);
        repeat (2) @(posedge sys_clk_i);
        chk("share", {28'h0, r[3:1], ~r[0]}, {28'h0, pin_o[3:0]});
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h10, 32'h0);
        r = 8'($random(seed));
        ext_en <= 8'hFF;
        ext_val <= ~r;
        apb(1'b1, 8'h24, {24'h0, r});
        apb(1'b1, 8'h20, 32'h41);
        repeat (8) @(posedge sys_clk_i);
        apb(1'b0, 8'h20, 32'h0);
        chk("early", 32'h0, {31'h0, rd[STS_VALID]});
        ext_val <= r;
        wait_ev(2);
        apb(1'b0, 8'h24, 32'h0);
        chk("sample", {24'h0, r}, rd & 32'hFF);
        tdiff(8'h28, 0, 32'h3);
        apb(1'b1, 8'h44, 32'h300);
        apb(1'b1, 8'h20, 32'h101);
        tdiff(8'h28, 9, 32'h3);
        ext_en <= 8'h00;
        apb(1'b1, 8'h48, 32'h101);
        apb(1'b1, 8'h10, 32'h201);
        apb(1'b0, 8'h18, 32'h0);
        t0 = rd;
        clk_run <= 1'b1;
        repeat (32) @(posedge sys_clk_i);
        clk_run <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        apb(1'b0, 8'h18, 32'h0);
        chk("pinclk", 32'h4, (rd - t0) & 32'hFFFF);
        apb(1'b1, 8'h10, 32'hB);
        apb(1'b0, 8'h18, 32'h0);
        t0 = (rd + 32'd40) & 32'hFFFF;
        apb(1'b1, 8'h18, t0);
        apb(1'b1, 8'h14, {28'h0, r[3:0]});
        wait_ev(1);
        apb(1'b0, 8'h1C, 32'h0);
        chk("stamp", t0, rd & 32'hFFFF);
        apb(1'b1, 8'h20, 32'h3);
        apb(1'b1, 8'h24, 32'hFF);
        wait_ev(2);
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, 8'h20, 32'h33);
        w = $random(seed);
        s0 = stb_seen;
        apb(1'b1, 8'h24, w);
        repeat (2) @(posedge sys_clk_i);
        for (int j = 0; j < 4; j++) begin
            @(posedge sys_clk_i);
            chk("chunk", {24'h0, w[8*j +: 8]}, {24'h0, pin_o});
        end
        chk("strobe", 32'h4, 32'(stb_seen - s0));
        apb(1'b1, LINK_CTRL, 32'h1);
        repeat (4) @(posedge sys_clk_i);
        chk("link", 32'h0, {30'h0, pin_oe_o[7:6]});
        chk("wide", 32'h3, {30'h0, pin_oe_o[5:4]});
        print_verdict();
    end
endmodule

// File: hw/ciop_pkg.sv
// Shared constants for the clocked I/O port unit and its clock blocks.
package ciop_pkg;
    localparam int NPORT = 3;
    localparam int NPIN = 8;
    localparam int NCB = 6;
    localparam int LINK_PINS = 2;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    localparam int PORT_W [NPORT] = '{1, 4, 8};
    localparam int REF_CLOCK_MHZ = 100;
    localparam logic [7:0] PORT_STRIDE = 8'h10;
    localparam logic [7:0] PORT_CTRL = 8'h00;
    localparam logic [7:0] PORT_DATA = 8'h04;
    localparam logic [7:0] PORT_TIME = 8'h08;
    localparam logic [7:0] PORT_STAMP = 8'h0C;
    localparam logic [7:0] CB_BASE = 8'h40;
    localparam logic [7:0] LINK_CTRL = 8'h60;
    localparam int CTL_EN = 0;
    localparam int CTL_OUT = 1;
    localparam int CTL_OD = 2;
    localparam int CTL_TIMED = 3;
    localparam int CTL_STB = 4;
    localparam int CTL_SER = 5;
    localparam int CTL_COND = 6;
    localparam int CTL_CB = 8;
    localparam int CTL_W = 11;
    localparam int STS_VALID = 16;
    localparam int STS_PEND = 17;
    localparam logic [CTL_W-1:0] CTL_RESET = 11'h000;
    localparam int CB_SRC = 0;
    localparam int CB_DIV = 8;
    localparam logic [15:0] CB_RESET = 16'h0000;
    typedef enum logic [1:0] {
        COND_NONE = 2'b00,
        COND_EQ = 2'b01,
        COND_NEQ = 2'b10
    } ciop_cond_t;
endpackage

// File: hw/ciop_top.sv
// Clocked I/O port unit with clock blocks, pin sharing and an APB register slave.
//
// Summary of operation
// - Ports of several fixed widths, each mapped onto a fixed group of pins.
// - One direction bit per port; all its pins share that direction.
// - Ports drive pins high or low, or sample them, optionally waiting for a condition.
// - Every register access is answered with no wait state.
// - Per-port open-drain: a zero pulls low, a one releases the pin.
// - Data passes through a shift serialiser and a transfer register.
// - A 16-bit counter per port times transfers between pins and transfer register.
// - Counter readable any time; a transfer can wait for a software target value.
// - Each transfer captures the counter into a readable timestamp.
// - An enabled link takes its shared pins away from every port.
// - An enabled narrower port overrides wider ports on shared pins.
// - Unshared pins of a wider port stay with the wider port.
// - A port always transfers at its own width, whatever pins it owns.
// - Six clock blocks; block zero is the fixed reference clock.
// - Blocks one to five can divide down to other rates.
// - A clock block can use the 1-bit port pin as its clock source.
// - The clock taken from the 1-bit port can be divided before use.
// - Ports accept an input strobe and can emit an output strobe.
// - After reset every port uses clock block zero.
// - Completed port transfers raise event pulses, not interrupts.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module ciop_top
    import ciop_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [NPIN-1:0] pin_i,
    output logic [NPIN-1:0] pin_o,
    output logic [NPIN-1:0] pin_oe_o,
    input wire logic [NPORT-1:0] strobe_in_i,
    output logic [NPORT-1:0] strobe_out_o,
    output logic [NPORT-1:0] event_o
);
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic acc;
    logic wr;
    logic rd;
    logic setup;
    logic [1:0] rd_port;
    logic [2:0] cb_idx;
    logic link_en_q;
    logic link_en_d;
    logic pin0_prev_q;
    logic [NCB-1:0] cb_tick;
    logic [15:0] cb_cfg_q [NCB];
    logic [CTL_W-1:0] ctrl_q [NPORT];
    logic [31:0] xfer_q [NPORT];
    logic [CNT_W-1:0] cnt_q [NPORT];
    logic [CNT_W-1:0] target_q [NPORT];
    logic [CNT_W-1:0] stamp_q [NPORT];
    logic [NPORT-1:0] valid_q;
    logic [NPORT-1:0] pend_q;
    logic [NPORT-1:0] stb_q;
    logic [NPORT-1:0] evt_q;
    logic [NPIN-1:0] drv_q [NPORT];
    logic [NPIN-1:0] pin_eff;
    logic [NPIN-1:0] pin_o_q;
    logic [NPIN-1:0] pin_o_d;
    logic [NPIN-1:0] pin_oe_q;
    logic [NPIN-1:0] pin_oe_d;

    // Zero wait states: ready is raised in the access phase of every transfer.
    assign acc = psel_i & penable_i & pready_q;
    assign wr = acc & pwrite_i;
    assign rd = acc & ~pwrite_i;
    assign setup = psel_i & ~penable_i;
    assign rd_port = paddr_i[5:4];
    assign cb_idx = 3'((paddr_i - CB_BASE) >> 2);

    // Link-owned pins read as zero to the ports.
    always_comb begin
        pin_eff = pin_i;
        if (link_en_q) begin
            pin_eff[NPIN-1 -: LINK_PINS] = '0;
        end
    end

    // Clock blocks. Block zero ticks every cycle; the others divide the reference or pin edges.
    for (genvar c = 0; c < NCB; c++) begin : g_cb
        logic [7:0] div_q, div_d;
        logic [15:0] cfg_d;
        logic src_edge;
        if (c == 0) begin : g_ref
            assign cb_tick[c] = 1'b1;
            assign src_edge = 1'b1;
            assign div_d = '0;
            assign cfg_d = CB_RESET;
        end else begin : g_prog
            // The pin is synchronous, so its rising edge is taken from the last sample.
            assign src_edge = cb_cfg_q[c][CB_SRC]
                ? (pin_eff[0] & ~pin0_prev_q) : 1'b1;
            assign cb_tick[c] = src_edge && (div_q == cb_cfg_q[c][CB_DIV +: 8]);
            always_comb begin
                cfg_d = cb_cfg_q[c];
                div_d = div_q;
                if (wr && paddr_i == CB_BASE + 8'(4 * c)) begin
                    cfg_d = pwdata_i[15:0];
                    div_d = '0;
                end else if (src_edge) begin
                    div_d = cb_tick[c] ? 8'h00 : div_q + 8'h01;
                end
            end
        end
        always_ff @(posedge sys_clk_i) begin
            if (reset_i) begin
                cb_cfg_q[c] <= CB_RESET;
                div_q <= 8'h00;
            end else begin
                cb_cfg_q[c] <= cfg_d;
                div_q <= div_d;
            end
        end
    end

    // Per-port logic.
    for (genvar i = 0; i < NPORT; i++) begin : g_port
        localparam int W = PORT_W[i];
        localparam int NCH = 32 / W;
        logic [CTL_W-1:0] ctrl_d;
        logic [31:0] xfer_d, shift_q, shift_d;
        logic [CNT_W-1:0] cnt_d, target_d, stamp_d;
        logic [W-1:0] cmp_q;
        logic [W-1:0] cmp_d;
        logic [W-1:0] samp;
        logic [5:0] chunk_q;
        logic [5:0] chunk_d;
        logic [NPIN-1:0] drv_d;
        logic valid_d, pend_d, stb_d, evt_d, tick, sel, hit_time, match, last;
        logic [2:0] cbsel;
        ciop_cond_t cond;
        logic wr_ctrl;
        logic wr_time;
        logic wr_data;
        logic rd_data;

        assign sel = (paddr_i & ~(PORT_STRIDE - 8'h01)) == 8'(i) * PORT_STRIDE;
        assign cbsel = ctrl_q[i][CTL_CB +: 3];
        assign tick = ctrl_q[i][CTL_EN] && (32'(cbsel) < NCB) && cb_tick[cbsel];
        assign samp = pin_eff[W-1:0];
        assign cond = ciop_cond_t'(ctrl_q[i][CTL_COND +: 2]);
        assign hit_time = !ctrl_q[i][CTL_TIMED] || cnt_q[i] == target_q[i];
        assign match = cond == COND_NONE || (cond == COND_EQ && samp == cmp_q)
            || (cond == COND_NEQ && samp != cmp_q);
        assign last = !ctrl_q[i][CTL_SER] || chunk_q == 6'(NCH - 1);
        assign wr_ctrl = wr && sel && paddr_i[3:0] == PORT_CTRL[3:0];
        assign wr_time = wr && sel && paddr_i[3:0] == PORT_TIME[3:0];
        assign wr_data = wr && sel && paddr_i[3:0] == PORT_DATA[3:0];
        assign rd_data = rd && sel && paddr_i[3:0] == PORT_DATA[3:0];

        always_comb begin
            ctrl_d = ctrl_q[i];
            xfer_d = xfer_q[i];
            shift_d = shift_q;
            cnt_d = cnt_q[i];
            target_d = target_q[i];
            stamp_d = stamp_q[i];
            cmp_d = cmp_q;
            chunk_d = chunk_q;
            drv_d = drv_q[i];
            valid_d = valid_q[i];
            pend_d = pend_q[i];
            stb_d = 1'b0;
            evt_d = 1'b0;
            // A read drains the transfer register; a new word on the same edge wins.
            if (rd_data) begin
                valid_d = 1'b0;
            end

            if (tick) begin
                cnt_d = cnt_q[i] + 16'h0001;
                if (ctrl_q[i][CTL_OUT] && pend_q[i] && (chunk_q != '0 || hit_time)) begin
                    drv_d = NPIN'(shift_q[W-1:0]);
                    shift_d = shift_q >> W;
                    stb_d = ctrl_q[i][CTL_STB];
                    ctrl_d[CTL_TIMED] = 1'b0;
                    if (chunk_q == '0) begin
                        stamp_d = cnt_q[i];
                    end
                    chunk_d = chunk_q + 6'h01;
                    if (last) begin
                        pend_d = 1'b0;
                        chunk_d = '0;
                        evt_d = 1'b1;
                    end
                end else if (!ctrl_q[i][CTL_OUT] && (chunk_q != '0 || (hit_time && match))
                        && (!ctrl_q[i][CTL_STB] || strobe_in_i[i])) begin
                    shift_d = {samp, shift_q[31:W]};
                    chunk_d = chunk_q + 6'h01;
                    if (chunk_q == '0) begin
                        stamp_d = cnt_q[i];
                    end
                    if (last) begin
                        xfer_d = ctrl_q[i][CTL_SER] ? shift_d : 32'(samp);
                        valid_d = 1'b1;
                        chunk_d = '0;
                        evt_d = 1'b1;
                        ctrl_d[CTL_COND +: 2] = COND_NONE;
                        ctrl_d[CTL_TIMED] = 1'b0;
                    end
                end
            end

            // Software writes come last, so a word written on the edge that ends
            // the previous one is kept and restarts the transfer.
            if (wr_ctrl) begin
                ctrl_d = pwdata_i[CTL_W-1:0];
            end
            if (wr_time) begin
                target_d = pwdata_i[CNT_W-1:0];
            end
            if (wr_data) begin
                if (ctrl_q[i][CTL_OUT]) begin
                    shift_d = pwdata_i;
                    xfer_d = pwdata_i;
                    pend_d = 1'b1;
                    chunk_d = '0;
                end else begin
                    cmp_d = pwdata_i[W-1:0];
                end
            end
        end

        always_ff @(posedge sys_clk_i) begin
            if (reset_i) begin
                ctrl_q[i] <= CTL_RESET;
                xfer_q[i] <= 32'h00000000;
                shift_q <= 32'h00000000;
                cnt_q[i] <= 16'h0000;
                target_q[i] <= 16'h0000;
                stamp_q[i] <= 16'h0000;
                cmp_q <= '0;
                chunk_q <= 6'h00;
                drv_q[i] <= 8'h00;
                valid_q[i] <= 1'b0;
                pend_q[i] <= 1'b0;
                stb_q[i] <= 1'b0;
                evt_q[i] <= 1'b0;
            end else begin
                ctrl_q[i] <= ctrl_d;
                xfer_q[i] <= xfer_d;
                shift_q <= shift_d;
                cnt_q[i] <= cnt_d;
                target_q[i] <= target_d;
                stamp_q[i] <= stamp_d;
                cmp_q <= cmp_d;
                chunk_q <= chunk_d;
                drv_q[i] <= drv_d;
                valid_q[i] <= valid_d;
                pend_q[i] <= pend_d;
                stb_q[i] <= stb_d;
                evt_q[i] <= evt_d;
            end
        end
    end

    // Pin ownership: the narrowest enabled port covering a pin drives it.
    always_comb begin
        pin_o_d = '0;
        pin_oe_d = '0;
        for (int p = 0; p < NPIN; p++) begin
            for (int k = NPORT - 1; k >= 0; k--) begin
                if (ctrl_q[k][CTL_EN] && p < PORT_W[k]) begin
                    if (!ctrl_q[k][CTL_OUT]) begin
                        pin_o_d[p] = 1'b0;
                        pin_oe_d[p] = 1'b0;
                    end else if (ctrl_q[k][CTL_OD]) begin
                        pin_o_d[p] = 1'b0;
                        pin_oe_d[p] = ~drv_q[k][p];
                    end else begin
                        pin_o_d[p] = drv_q[k][p];
                        pin_oe_d[p] = 1'b1;
                    end
                end
            end
            if (link_en_q && p >= NPIN - LINK_PINS) begin
                pin_o_d[p] = 1'b0;
                pin_oe_d[p] = 1'b0;
            end
        end
    end

    // Pin register: drive, enable and the pin 0 history for edge detection.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pin0_prev_q <= 1'b0;
            pin_o_q <= 8'h00;
            pin_oe_q <= 8'h00;
        end else begin
            pin0_prev_q <= pin_eff[0];
            pin_o_q <= pin_o_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    // Link enable. The pin mux and the port inputs both read the registered value, so the ports
    // lose the shared pins on the edge that sets it and the pin register releases them one edge later.
    always_comb begin
        link_en_d = link_en_q;
        if (wr && paddr_i == LINK_CTRL) begin
            link_en_d = pwdata_i[0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            link_en_q <= 1'b0;
        end else begin
            link_en_q <= link_en_d;
        end
    end

    // APB read mux and unmapped-address error, prepared in the setup phase.
    always_comb begin
        pready_d = setup;
        prdata_d = 32'h00000000;
        pslverr_d = 1'b0;
        if (!setup) begin
            // Read data stands until the next setup; the error lasts one cycle only.
            prdata_d = prdata_q;
        end else if (paddr_i == LINK_CTRL) begin
            prdata_d = {31'h00000000, link_en_q};
        end else if (paddr_i >= CB_BASE && paddr_i < CB_BASE + 8'(4 * NCB)
                && paddr_i[1:0] == 2'b00) begin
            prdata_d = {16'h0000, cb_cfg_q[cb_idx]};
        end else if (paddr_i < 8'(NPORT) * PORT_STRIDE && paddr_i[1:0] == 2'b00) begin
            if (paddr_i[3:0] == PORT_CTRL[3:0]) begin
                prdata_d = 32'(ctrl_q[rd_port])
                    | (32'(pend_q[rd_port]) << STS_PEND)
                    | (32'(valid_q[rd_port]) << STS_VALID);
            end else if (paddr_i[3:0] == PORT_DATA[3:0]) begin
                prdata_d = xfer_q[rd_port];
            end else if (paddr_i[3:0] == PORT_TIME[3:0]) begin
                prdata_d = 32'(cnt_q[rd_port]);
            end else begin
                prdata_d = 32'(stamp_q[rd_port]);
            end
        end else begin
            pslverr_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign pin_o = pin_o_q;
    assign pin_oe_o = pin_oe_q;
    assign strobe_out_o = stb_q;
    assign event_o = evt_q;
endmodule
